// ==== dv/tmrg_timer1_ctrl_tb.sv ====
// self-checking bench for the timer one control and gate block
// assumes the src/ package and design files are compiled first
`timescale 1ns/1ps
module tmrg_timer1_ctrl_tb;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic ext = 1'b1;
	logic gpin = 1'b0;
	logic cmp = 1'b0;
	logic slp = 1'b0;
	logic [31:0] prdata;
	logic pready, perr, tinc, osc, ovf, irq, err_s;
	logic [31:0] rd;
	logic [15:0] cnt;
	int n_fail = 0;
	int check_count = 0;
	int k;
	int n_inc;
	logic ce = 1'b1;
	tmrg_timer1_ctrl uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wd), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(perr), .external_count_input_i(ext),
		.gate_pin_i(gpin), .second_comparator_output_i(cmp), .sleep_i(slp),
		.timer_inc_o(tinc), .low_power_osc_enable_o(osc), .overflow_flag_o(ovf), .irq_o(irq));
	initial begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	// ----------------------------------------
	// report and compare
	// ----------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
		check_count++;
		if ((^got === 1'bx) || got < lo || got > hi) begin
			n_fail++;
			$display("Error %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask : chk_rng
	// ----------------------------------------
	// apb access and count helpers
	// ----------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys_i);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk_sys_i);
		pen <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk_sys_i);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			n_fail++;
			end_of_test();
		end
		rd = prdata;
		err_s = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic setcnt(input logic [15:0] v);
		wr(tmrg_pkg::OFF_LOW, {24'h0, v[7:0]});
		wr(tmrg_pkg::OFF_HIGH, {24'h0, v[15:8]});
	endtask : setcnt
	task automatic rdcnt();
		apb(1'b0, tmrg_pkg::OFF_LOW, 32'h0);
		cnt[7:0] = rd[7:0];
		apb(1'b0, tmrg_pkg::OFF_HIGH, 32'h0);
		cnt[15:8] = rd[7:0];
	endtask : rdcnt
	task automatic run_win(input logic [7:0] c, input int n);
		setcnt(16'h0000);
		wr(tmrg_pkg::OFF_CTRL, {24'h0, c});
		n_inc = 0;
		repeat (n) begin
			@(negedge clk_sys_i);
			if (tinc === 1'b1) n_inc++;
		end
		wr(tmrg_pkg::OFF_CTRL, 32'h0);
		rdcnt();
	endtask : run_win
	task automatic ext_win(input logic [7:0] c);
		ext <= 1'b1;
		setcnt(16'h0000);
		wr(tmrg_pkg::OFF_CTRL, {24'h0, c});
		repeat (8) @(posedge clk_sys_i);
		for (int i = 0; i < 10; i++) begin
			ext <= 1'b0;
			repeat (8) @(posedge clk_sys_i);
			ext <= 1'b1;
			repeat (8) @(posedge clk_sys_i);
		end
		wr(tmrg_pkg::OFF_CTRL, 32'h0);
		rdcnt();
	endtask : ext_win
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		apb(1'b0, tmrg_pkg::OFF_CTRL, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, err_s}, 32'h0);
		apb(1'b0, tmrg_pkg::OFF_AUX, 32'h0);
		chk(rd, 32'h2);
		apb(1'b0, tmrg_pkg::OFF_MASK, 32'h0);
		chk(rd, 32'h0);
		wr(8'h1C, 32'h0000_00FF);
		chk({31'h0, err_s}, 32'h1);
		apb(1'b0, 8'h18, 32'h0);
		chk({31'h0, err_s}, 32'h1);
		chk(rd, 32'h0);
		wr(tmrg_pkg::OFF_CTRL, 32'h0000_0008);
		#1 chk({31'h0, osc}, 32'h1);
		apb(1'b0, tmrg_pkg::OFF_CTRL, 32'h0);
		chk(rd, 32'h8);
		setcnt(16'hA55A);
		repeat (64) @(posedge clk_sys_i);
		rdcnt();
		chk({16'h0, cnt}, 32'hA55A);
		for (k = 0; k < 4; k++) begin
			run_win({2'b00, k[1:0], 4'h1}, 256);
			chk_rng(cnt, (64 >> k) - 2, (64 >> k) + 2);
			chk(n_inc, 32'h40 >> k);
		end
		setcnt(16'h0000);
		wr(tmrg_pkg::OFF_CTRL, 32'h1);
		repeat (40) @(posedge clk_sys_i);
		ce <= 1'b0;
		repeat (64) @(posedge clk_sys_i);
		ce <= 1'b1;
		wr(tmrg_pkg::OFF_CTRL, 32'h0);
		rdcnt();
		chk_rng(cnt, 9, 12);
		run_win(8'h05, 256);
		chk_rng(cnt, 62, 66);
		gpin <= 1'b1;
		wr(tmrg_pkg::OFF_AUX, 32'h0);
		run_win(8'h41, 256);
		chk({16'h0, cnt}, 32'h0);
		chk(n_inc, 32'h40);
		cmp <= 1'b1;
		run_win(8'hC1, 256);
		chk_rng(cnt, 62, 66);
		gpin <= 1'b0;
		wr(tmrg_pkg::OFF_AUX, 32'h3);
		run_win(8'h41, 256);
		chk({16'h0, cnt}, 32'h0);
		chk(n_inc, 32'h40);
		run_win(8'hC1, 256);
		chk_rng(cnt, 62, 66);
		wr(tmrg_pkg::OFF_AUX, 32'h2);
		run_win(8'h41, 256);
		chk({16'h0, cnt}, 32'h0);
		ext_win(8'h03);
		chk({16'h0, cnt}, 32'hA);
		slp <= 1'b1;
		ext_win(8'h03);
		chk({16'h0, cnt}, 32'h0);
		ext_win(8'h07);
		chk({16'h0, cnt}, 32'hA);
		slp <= 1'b0;
		wr(tmrg_pkg::OFF_MASK, 32'h1);
		setcnt(16'hFFFF);
		wr(tmrg_pkg::OFF_CTRL, 32'h1);
		repeat (16) @(posedge clk_sys_i);
		wr(tmrg_pkg::OFF_CTRL, 32'h0);
		#1 chk({30'h0, ovf, irq}, 32'h3);
		wr(tmrg_pkg::OFF_MASK, 32'h0);
		#1 chk({30'h0, ovf, irq}, 32'h2);
		apb(1'b0, tmrg_pkg::OFF_STATUS, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, tmrg_pkg::OFF_STATUS, 32'h0);
		chk(rd, 32'h0);
		#1 chk({31'h0, ovf}, 32'h0);
		setcnt(16'h1234);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rdcnt();
		chk({16'h0, cnt}, 32'h1234);
		end_of_test();
	end
	initial begin
		#400000;
		n_fail++;
		end_of_test();
	end
endmodule : tmrg_timer1_ctrl_tb

// ==== src/tmrg_pkg.sv ====
// timer one control and gate: shared offsets, field positions, reset values
// assumes a 32-bit apb slave with byte addresses on an 8-bit paddr
package tmrg_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_LOW = 8'h04;
	localparam logic [7:0] OFF_HIGH = 8'h08;
	localparam logic [7:0] OFF_AUX = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_MASK = 8'h14;
	// ----------------------------------------
	// timer_one_control fields
	// ----------------------------------------
	localparam int RUN_BIT = 0;
	localparam int CS_BIT = 1;
	localparam int BYPASS_BIT = 2;
	localparam int OSC_BIT = 3;
	localparam int PS_LSB = 4;
	localparam int GE_BIT = 6;
	localparam int GINV_BIT = 7;
	// ----------------------------------------
	// comparator_aux_control fields
	// ----------------------------------------
	localparam int AUX_SYNC_BIT = 0;
	localparam int AUX_GSS_BIT = 1;
	// ----------------------------------------
	// reset values and counts
	// ----------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] AUX_RST = 2'h2;
	localparam logic MASK_RST = 1'b0;
	localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
endpackage : tmrg_pkg

// ==== src/tmrg_prescale.sv ====
// prescale counter dividing input ticks by 1, 2, 4 or 8
// assumes ticks are one-cycle pulses on the system clock
`timescale 1ns/1ps
module tmrg_prescale #(
	parameter int W = 3
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic clr_i,
	input wire logic tick_i,
	input wire logic [1:0] sel_i,
	output logic tick_o,
	output logic [W-1:0] cnt_o
);
	logic [W-1:0] cnt_q;
	wire [W-1:0] limit = W'((4'h1 << sel_i) - 4'h1);
	wire at_limit = (cnt_q >= limit);
	assign tick_o = tick_i && at_limit && !clr_i;
	assign cnt_o = cnt_q;
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else if (ce_i) begin
			if (clr_i || (tick_i && at_limit)) begin
				cnt_q <= '0;
			end else if (tick_i) begin
				cnt_q <= cnt_q + W'(1);
			end
		end
	end
endmodule : tmrg_prescale

// ==== src/tmrg_sync3.sv ====
// three-flop input synchroniser, level changes once stages two and three agree
// assumes an asynchronous input and one system clock
`timescale 1ns/1ps
module tmrg_sync3 (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic async_i,
	output logic level_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_o <= 1'b0;
		end else if (ce_i) begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_o <= s3_q;
			end
		end
	end
endmodule : tmrg_sync3

// ==== src/tmrg_timer1_ctrl.sv ====
// timer one control and gate: apb registers, clock select, gate, 16-bit count
// assumes apb master on clk_sys_i; count, gate and comparator pins asynchronous
//
// Contract
// R01: increment clock offered to sync comparator output
// R02: synced comparator gate never loses an increment
// R03: run bit counts; cleared holds the count
// R04: gate enable bit; aux select picks source
// R05: count as low and high byte registers
// R06: invert set counts gate high, else low
// R07: prescale 1,2,4,8; count write clears prescaler
// R08: source bit picks external rising edge input
// R09: bypass bit skips sync, counts during sleep
// R10: rollover sets sticky overflow flag
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module tmrg_timer1_ctrl (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic external_count_input_i,
	input wire logic gate_pin_i,
	input wire logic second_comparator_output_i,
	input wire logic sleep_i,
	output logic timer_inc_o,
	output logic low_power_osc_enable_o,
	output logic overflow_flag_o,
	output logic irq_o
);
	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	logic [7:0] ctrl_q;
	logic [1:0] aux_q;
	logic [15:0] count_q;
	logic status_q;
	logic mask_q;
	logic [31:0] prdata_q;
	logic [1:0] idiv_q;
	logic ext_prev_q;
	logic armed_q;
	logic pend_q;
	logic cmp_q;
	logic ext_lvl;
	logic pin_lvl;
	logic cmp_lvl;
	logic pre_tick;
	logic [2:0] pre_cnt;
	logic lo_known_q;
	logic hi_known_q;

	wire setup = psel_i && !penable_i;
	wire access = psel_i && penable_i;
	wire mapped = hit(paddr_i, tmrg_pkg::OFF_CTRL) || hit(paddr_i, tmrg_pkg::OFF_LOW)
		|| hit(paddr_i, tmrg_pkg::OFF_HIGH) || hit(paddr_i, tmrg_pkg::OFF_AUX)
		|| hit(paddr_i, tmrg_pkg::OFF_STATUS) || hit(paddr_i, tmrg_pkg::OFF_MASK);
	wire wr_en = access && pwrite_i && ce_i;
	wire rd_en = access && !pwrite_i && ce_i;
	wire wr_ctrl = wr_en && hit(paddr_i, tmrg_pkg::OFF_CTRL);
	wire wr_low = wr_en && hit(paddr_i, tmrg_pkg::OFF_LOW);
	wire wr_high = wr_en && hit(paddr_i, tmrg_pkg::OFF_HIGH);
	wire wr_aux = wr_en && hit(paddr_i, tmrg_pkg::OFF_AUX);
	wire wr_mask = wr_en && hit(paddr_i, tmrg_pkg::OFF_MASK);
	wire rd_status = rd_en && hit(paddr_i, tmrg_pkg::OFF_STATUS);
	wire cnt_wr = wr_low || wr_high;
	wire count_known = lo_known_q && hi_known_q;

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	wire run = ctrl_q[tmrg_pkg::RUN_BIT];
	wire cs_ext = ctrl_q[tmrg_pkg::CS_BIT];
	wire bypass = cs_ext && ctrl_q[tmrg_pkg::BYPASS_BIT];
	wire [1:0] ps_sel = ctrl_q[tmrg_pkg::PS_LSB +: 2];
	wire gate_en = ctrl_q[tmrg_pkg::GE_BIT];
	wire gate_inv = ctrl_q[tmrg_pkg::GINV_BIT];
	wire gss = aux_q[tmrg_pkg::AUX_GSS_BIT];
	wire cmp_sync_en = aux_q[tmrg_pkg::AUX_SYNC_BIT];

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	tmrg_sync3 u_ext_sync (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.async_i(external_count_input_i),
		.level_o(ext_lvl)
	);
	tmrg_sync3 u_gate_sync (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.async_i(gate_pin_i),
		.level_o(pin_lvl)
	);
	tmrg_sync3 u_cmp_sync (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.async_i(second_comparator_output_i),
		.level_o(cmp_lvl)
	);

	// ----------------------------------------
	// clock source selection
	// ----------------------------------------
	wire int_tick = (idiv_q == tmrg_pkg::INSTR_DIV_LAST);
	// a falling edge must arm the counter before the first rising edge counts
	wire ext_rise = ext_lvl && !ext_prev_q && armed_q;
	wire sync_tick = int_tick && (pend_q || ext_rise);
	wire ext_tick = bypass ? ext_rise : sync_tick; // R09
	wire src_tick = cs_ext ? ext_tick : int_tick; // R08
	wire awake = !sleep_i || bypass; // R09
	wire pre_in = src_tick && awake && run; // R03

	tmrg_prescale #(
		.W(3)
	) u_pre (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.clr_i(cnt_wr), // R07
		.tick_i(pre_in),
		.sel_i(ps_sel),
		.tick_o(pre_tick),
		.cnt_o(pre_cnt)
	);

	// ----------------------------------------
	// gate
	// ----------------------------------------
	wire cmp_gate = cmp_sync_en ? cmp_q : cmp_lvl; // R02
	wire gate_raw = gss ? cmp_gate : pin_lvl; // R04
	wire gate_active = !(gate_raw ^ gate_inv); // R06
	wire gate_ok = !gate_en || gate_active; // R04
	wire inc = pre_tick && gate_ok && !cnt_wr;
	wire ovf = inc && (count_q == tmrg_pkg::COUNT_MAX); // R10

	assign timer_inc_o = pre_tick; // R01
	assign low_power_osc_enable_o = ctrl_q[tmrg_pkg::OSC_BIT];
	assign overflow_flag_o = status_q;
	assign irq_o = status_q && mask_q;

	// ----------------------------------------
	// apb answer
	// ----------------------------------------
	wire [31:0] rd_mux = hit(paddr_i, tmrg_pkg::OFF_CTRL) ? {24'h000000, ctrl_q}
		: hit(paddr_i, tmrg_pkg::OFF_LOW) ? {24'h000000, count_q[7:0]}
		: hit(paddr_i, tmrg_pkg::OFF_HIGH) ? {24'h000000, count_q[15:8]}
		: hit(paddr_i, tmrg_pkg::OFF_AUX) ? {30'h00000000, aux_q}
		: hit(paddr_i, tmrg_pkg::OFF_STATUS) ? {31'h00000000, status_q}
		: hit(paddr_i, tmrg_pkg::OFF_MASK) ? {31'h00000000, mask_q}
		: 32'h00000000;
	assign pready_o = access;
	assign pslverr_o = access && !mapped;
	assign prdata_o = prdata_q;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q <= tmrg_pkg::CTRL_RST;
			aux_q <= tmrg_pkg::AUX_RST;
			mask_q <= tmrg_pkg::MASK_RST;
			status_q <= 1'b0;
			prdata_q <= 32'h00000000;
			lo_known_q <= 1'b0;
			hi_known_q <= 1'b0;
		end else if (ce_i) begin
			if (wr_ctrl) begin
				ctrl_q <= pwdata_i[7:0];
			end
			if (wr_aux) begin
				aux_q <= pwdata_i[1:0];
			end
			if (wr_mask) begin
				mask_q <= pwdata_i[0];
			end
			if (wr_low) begin
				lo_known_q <= 1'b1;
			end
			if (wr_high) begin
				hi_known_q <= 1'b1;
			end
			status_q <= ovf || (status_q && !rd_status); // R10
			if (setup) begin
				prdata_q <= rd_mux;
			end
		end
	end

	// count holds its value through reset, undefined until written
	always_ff @(posedge clk_sys_i) begin
		if (ce_i) begin
			if (wr_low) begin
				count_q[7:0] <= pwdata_i[7:0]; // R05
			end else if (wr_high) begin
				count_q[15:8] <= pwdata_i[7:0]; // R05
			end else if (inc) begin
				count_q <= count_q + 16'h0001; // R03
			end
		end
	end

	// ----------------------------------------
	// edge tracking and comparator sync
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			idiv_q <= 2'h0;
			ext_prev_q <= 1'b0;
			armed_q <= 1'b0;
			pend_q <= 1'b0;
			cmp_q <= 1'b0;
		end else if (ce_i) begin
			idiv_q <= 2'(idiv_q + 2'h1);
			ext_prev_q <= ext_lvl;
			if (cnt_wr || !run) begin
				armed_q <= 1'b0;
			end else if (!ext_lvl) begin
				armed_q <= 1'b1;
			end
			pend_q <= ext_rise && !int_tick && !bypass;
			if (pend_q && !int_tick && !bypass) begin
				pend_q <= 1'b1;
			end
			if (pre_tick) begin
				cmp_q <= cmp_lvl; // R01
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	property p_inc_clock;
		ce_i && cmp_sync_en && !timer_inc_o |=> cmp_q == $past(cmp_q);
	endproperty
	a_inc_clock: assert property (p_inc_clock) else $error("comparator sync moved off tick"); // R01

	property p_cmp_gate;
		ce_i && gate_en && gss && cmp_sync_en && !timer_inc_o && !wr_aux
			|=> $stable(gate_raw);
	endproperty
	a_cmp_gate: assert property (p_cmp_gate) else $error("comparator gate not synced"); // R02

	property p_halt;
		ce_i && count_known && !run && !cnt_wr |=> count_q == $past(count_q);
	endproperty
	a_halt: assert property (p_halt) else $error("count moved while halted"); // R03

	property p_gate_src;
		ce_i && count_known && pre_tick && !cnt_wr && gate_en && !gss && (pin_lvl == gate_inv)
			|=> count_q == $past(count_q) + 16'h0001;
	endproperty
	a_gate_src: assert property (p_gate_src) else $error("wrong gate source"); // R04

	property p_low_write;
		wr_low |=> count_q[7:0] == $past(pwdata_i[7:0]);
	endproperty
	a_low_write: assert property (p_low_write) else $error("low byte write lost"); // R05

	property p_gate_pol;
		ce_i && gate_en && (gate_raw != gate_inv) |=> count_q == $past(count_q) || $past(cnt_wr);
	endproperty
	a_gate_pol: assert property (p_gate_pol) else $error("counted with gate inactive"); // R06

	property p_pre_clear;
		cnt_wr |=> pre_cnt == 3'h0;
	endproperty
	a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared"); // R07

	property p_int_src;
		ce_i && run && !cs_ext && !sleep_i && !cnt_wr && int_tick && (ps_sel == 2'h0)
			|-> timer_inc_o;
	endproperty
	a_int_src: assert property (p_int_src) else $error("internal clock not used"); // R08

	property p_sync_mode;
		cs_ext && !bypass && src_tick |-> int_tick;
	endproperty
	a_sync_mode: assert property (p_sync_mode) else $error("sync mode off instr tick"); // R09

	property p_sleep_hold;
		ce_i && count_known && sleep_i && !bypass && !cnt_wr |=> count_q == $past(count_q);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep"); // R09

	property p_ovf;
		ce_i && inc && count_q == tmrg_pkg::COUNT_MAX |=> status_q ##1 status_q || $past(rd_status);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag not set"); // R10
endmodule : tmrg_timer1_ctrl
